// File: core/true_peak_consts.svh
// What this block does
// R1: Zero-stuff input to four times the rate, then low-pass interpolate it.
// R2: Peak detection runs on the interpolated high-rate samples only.
// R3: Ratio chosen so 20*log10(cos(pi*fnorm/ratio)) under-read meets the target.
// R4: At eight times, under-read is 0.136 dB at 0.45, 0.169 dB at 0.5.
// R5: Interpolator is a symmetric FIR with just enough taps and word length.
// R6: With DC exclusion on, a first-order IIR high-pass sits at the input.
// R7: With DC exclusion off, DC is kept and included in the peak.
// R8: Larger rectified sample replaces reading, else reading decays by a factor.
// R9: Each interpolated sample is rectified by negating negative values.
// R10: Input attenuated 12.04 dB, unity restored by a two-bit left shift.
// R11: Interpolator is a four-phase polyphase FIR of 48 taps (order 47).
// R12: Reset clears the held peak and the filter history to zero.
`ifndef TRUE_PEAK_CONSTS_SVH
`define TRUE_PEAK_CONSTS_SVH

`define SAMPLE_W    24
`define DATA_W      26
`define COEF_W      16
`define COEF_FRAC   13
`define TAPS        12
`define PHASES      4
`define ACC_W       46
`define PEAK_W      28
`define ATTEN_SHIFT 2
`define DECAY_SHIFT 12
`define DC_SHIFT    10
`define HIST_RESET  26'h0000000
`define PEAK_RESET  28'h0000000

`endif

// File: core/true_peak_pkg.sv
`include "true_peak_consts.svh"

package true_peak_pkg;

    typedef enum logic {ST_IDLE, ST_RUN} meter_state_t;

    typedef struct packed {
        logic signed [`SAMPLE_W-1:0] data;
    } sample_in_t;

    typedef struct packed {
        logic        [`PEAK_W-1:0]   peak;
        logic signed [`DATA_W-1:0]   sample;
    } meter_out_t;

endpackage : true_peak_pkg

// File: core/true_peak_oversampling_meter.sv
`timescale 1ns/1ps
`include "true_peak_consts.svh"

module true_peak_oversampling_meter
    import true_peak_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Base-rate sample stream
    input  wire logic       in_valid_i,
    input  wire sample_in_t in_i,
    output logic            in_ready_o,
    // Configuration
    input  wire logic       dc_block_i,
    // Meter reading at the over-sampled rate
    output logic            out_valid_o,
    output meter_out_t      out_o
);

    // Phase count fixes the worst-case under-read of the reading [R3] [R4]
    // Phases 0 and 1 in Q13; phases 2 and 3 follow by symmetry
    localparam logic signed [`COEF_W-1:0] COEF_TAB [24] = '{
        16'h000e, 16'h005a, 16'hff5f, 16'h0110, 16'hfe19, 16'h0465,
        16'h1f1c, 16'hfcba, 16'h0186, 16'hff26, 16'h007a, 16'hffbc,
        16'hff11, 16'h00f0, 16'hfe58, 16'h02da, 16'hfaac, 16'h0ee2,
        16'h18f4, 16'hf997, 16'h0340, 16'hfe23, 16'h010f, 16'hff65
    };

    // Symmetric FIR: phase p tap k equals phase 3-p tap 11-k
    function automatic logic signed [`COEF_W-1:0] coef(
        input logic [1:0] ph,
        input int         k
    );
        int idx;
        if (ph < 2'h2) begin
            idx = int'(ph) * `TAPS + k;
        end else begin
            idx = (3 - int'(ph)) * `TAPS + (`TAPS - 1 - k);
        end
        return COEF_TAB[idx]; // [R5]
    endfunction : coef

    // Rectify, then restore the two bits dropped at the input
    function automatic logic [`PEAK_W-1:0] mag4(
        input logic signed [`DATA_W-1:0] v
    );
        logic [`DATA_W-1:0] m;
        m = v[`DATA_W-1] ? `DATA_W'(-v) : `DATA_W'(v); // [R9]
        return `PEAK_W'(m) << `ATTEN_SHIFT; // [R10]
    endfunction : mag4

    meter_state_t                state_q, state_d;
    logic        [1:0]           phase_q, phase_d;
    logic signed [`DATA_W-1:0]   hist_q [`TAPS];
    logic signed [`DATA_W-1:0]   hist_d [`TAPS];
    logic signed [`DATA_W-1:0]   dc_x1_q, dc_x1_d;
    logic signed [`DATA_W-1:0]   dc_y_q, dc_y_d;
    logic        [`PEAK_W-1:0]   peak_q, peak_d;
    logic signed [`DATA_W-1:0]   os_q, os_d;
    logic                        valid_q, valid_d;
    logic                        accept;
    logic                        run;
    logic signed [`DATA_W-1:0]   att_w;
    logic signed [`DATA_W-1:0]   stage_w;
    logic signed [`ACC_W-1:0]    acc_w;
    logic signed [`DATA_W-1:0]   os_w;
    logic signed [`DATA_W-1:0]   dc_out_w;
    logic        [`PEAK_W-1:0]   mag_full_w;
    logic        [`PEAK_W-1:0]   decayed_w;

    // Only idle accepts, so a new sample never disturbs a running burst
    assign in_ready_o = (state_q == ST_IDLE);
    assign accept     = in_valid_i && in_ready_o;
    assign run        = (state_q == ST_RUN);

    // Headroom for filter overshoot: drop 12.04 dB before interpolation
    assign att_w = `DATA_W'(in_i.data >>> `ATTEN_SHIFT); // [R10]

    // Input conditioning: optional DC blocker ahead of the over-sampler
    always_comb begin
        dc_x1_d  = dc_x1_q;
        dc_y_d   = dc_y_q;
        dc_out_w = att_w - dc_x1_q + dc_y_q
                   - (dc_y_q >>> `DC_SHIFT); // [R6]
        stage_w  = att_w; // [R7]
        if (!dc_block_i) begin
            // Keep state clean so switching on starts from zero
            dc_x1_d = `HIST_RESET;
            dc_y_d  = `HIST_RESET;
        end else begin
            stage_w = dc_out_w; // [R6]
            // State only advances on a taken sample
            if (accept) begin
                dc_x1_d = att_w;
                dc_y_d  = dc_out_w;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dc_x1_q <= `HIST_RESET;
            dc_y_q  <= `HIST_RESET;
        end else begin
            dc_x1_q <= dc_x1_d;
            dc_y_q  <= dc_y_d;
        end
    end

    // One polyphase branch per cycle; zero-stuffed taps are never summed
    always_comb begin
        acc_w = '0;
        for (int k = 0; k < `TAPS; k++) begin
            acc_w = acc_w + `ACC_W'(hist_q[k] * coef(phase_q, k)); // [R1] [R11]
        end
    end

    assign os_w       = $signed(acc_w[`COEF_FRAC +: `DATA_W]);
    // Most negative value cannot occur after the attenuation
    assign mag_full_w = mag4(os_w); // [R9] [R10]
    assign decayed_w  = peak_q - (peak_q >> `DECAY_SHIFT);

    // Sequencer, history shift and peak hold-and-decay
    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        hist_d  = hist_q;
        peak_d  = peak_q;
        os_d    = os_q;
        valid_d = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    for (int k = `TAPS - 1; k > 0; k--) begin
                        hist_d[k] = hist_q[k-1];
                    end
                    hist_d[0] = stage_w; // [R1]
                    phase_d   = 2'h0;
                    state_d   = ST_RUN;
                end
            end
            ST_RUN: begin
                os_d    = os_w;
                valid_d = 1'b1;
                if (mag_full_w > peak_q) begin
                    peak_d = mag_full_w; // [R2] [R8]
                end else begin
                    peak_d = decayed_w; // [R8]
                end
                phase_d = phase_q + 2'h1;
                if (phase_q == 2'h3) begin
                    state_d = ST_IDLE; // [R11]
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            phase_q <= 2'h0;
            peak_q  <= `PEAK_RESET; // [R12]
            os_q    <= `HIST_RESET;
            valid_q <= 1'b0;
            for (int k = 0; k < `TAPS; k++) begin
                hist_q[k] <= `HIST_RESET; // [R12]
            end
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            peak_q  <= peak_d;
            os_q    <= os_d;
            valid_q <= valid_d;
            hist_q  <= hist_d;
        end
    end

    // Registered outputs
    assign out_valid_o = valid_q;
    assign out_o       = {peak_q, os_q};

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_four_phases: assert property ( // [R11]
        accept |=> valid_d [*4] ##1 !valid_d)
        else $error("burst is not four phases");

    a_busy_refuse: assert property ( // [R1]
        accept |=> !in_ready_o [*4] ##1 in_ready_o)
        else $error("input accepted during a burst");

    a_hist_shift: assert property ( // [R1]
        accept |=> hist_q[1] == $past(hist_q[0]))
        else $error("history did not shift");

    a_dc_kept: assert property ( // [R7]
        accept && !dc_block_i |=> hist_q[0] == $past(att_w))
        else $error("DC path altered the sample");

    a_dc_blocked: assert property ( // [R6]
        accept && dc_block_i |=> hist_q[0] == $past(dc_out_w))
        else $error("DC blocker output not stored");

    a_peak_grows: assert property ( // [R8]
        run && mag_full_w > peak_q |=> peak_q == $past(mag_full_w))
        else $error("larger sample did not replace peak");

    a_peak_decays: assert property ( // [R8]
        run && mag_full_w <= peak_q |=> peak_q == $past(decayed_w))
        else $error("peak did not decay");

    a_peak_covers: assert property ( // [R2] [R9] [R10]
        out_valid_o |-> (out_o.peak >= mag4(os_q)) ||
            ($past(peak_q) >= mag4(os_q)))
        else $error("reading below the last sample");

    a_peak_idle: assert property (
        state_q == ST_IDLE && !$past(run) |=> $stable(peak_q))
        else $error("peak moved while idle");

    // From the second reset edge on: the first may still see power-up state
    a_reset_clear: assert property ( // [R12]
        @(posedge clk_i) disable iff (1'b0)
        !rst_n_i ##1 !rst_n_i |-> peak_q == `PEAK_RESET &&
            hist_q[0] == `HIST_RESET)
        else $error("reset did not clear state");

    c_burst: cover property (accept ##1 run [*4] ##1 !run);
    c_dc_on: cover property (accept && dc_block_i);
    c_grow:  cover property (run && mag_full_w > peak_q);
    c_decay: cover property (run && mag_full_w < peak_q && peak_q != 0);

endmodule : true_peak_oversampling_meter

// File: dv/sample_source.sv
`timescale 1ns/1ps
module sample_source
    import true_peak_pkg::*;
(
    // Clock and handshake
    input  wire logic clk_i,
    input  wire logic ready_i,
    // Offered sample
    output logic       valid_o,
    output sample_in_t data_o
);
    logic signed [23:0] held;
    logic        [23:0] idle = 24'h5a5a5a;

    initial valid_o = 1'b0;
    // Idle data flips each cycle so a stale word never looks valid
    always @(negedge clk_i) idle <= ~idle;
    assign data_o.data = valid_o ? held : idle;

    // Offer after a gap, hold until the meter takes it, then release
    task automatic push(input logic signed [23:0] x, input int gap);
        repeat (gap + 1) @(negedge clk_i);
        held = x;
        valid_o = 1'b1;
        while (ready_i !== 1'b1) @(negedge clk_i);
        @(negedge clk_i);
        valid_o = 1'b0;
    endtask : push
endmodule : sample_source

// File: dv/tb.sv
`timescale 1ns/1ps
module tb
    import true_peak_pkg::*;
;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       dc_block_i = 1'b0;
    logic       in_valid_i, in_ready_o, out_valid_o;
    sample_in_t in_i;
    meter_out_t out_o;
    int         n_mismatch = 0;
    int         checks = 0;
    int         ph = 0;
    int         since = 0;
    longint     hist[12], peak, acc, s, a, a1, y1;
    logic signed [23:0] takes[$];
    // Q13 taps, row k of the four phases; row 0 meets the newest sample
    localparam int H[48] = '{14, -239, -155, -68, 90, 240, 271, 122,
        -161, -424, -477, -218, 272, 730, 832, 390, -487, -1364, -1641,
        -838, 1125, 3810, 6388, 7964, 7964, 6388, 3810, 1125, -838, -1641,
        -1364, -487, 390, 832, 730, 272, -218, -477, -424, -161, 122, 271,
        240, 90, -68, -155, -239, 14};

    always #10 clk_i = ~clk_i;

    true_peak_oversampling_meter i_dut (.clk_i, .rst_n_i, .in_valid_i,
        .in_i, .in_ready_o, .dc_block_i, .out_valid_o, .out_o);
    sample_source i_src (.clk_i, .ready_i(in_ready_o),
        .valid_o(in_valid_i), .data_o(in_i));

    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Queue each accepted sample; inputs are stable here, so no race
    always @(posedge clk_i) begin
        since++;
        if (rst_n_i && in_valid_i && in_ready_o) begin
            takes.push_back(in_i.data);
            since = 0;
        end
    end

    // Reference interpolator and peak hold, one step per output sample
    always @(negedge clk_i) if (out_valid_o) begin
        if (ph == 0) begin
            check(28'(since), 28'd1);
            a = longint'(takes.pop_front()) >>> 2;
            for (int k = 11; k > 0; k--) hist[k] = hist[k-1];
            hist[0] = dc_block_i ? a - a1 + y1 - (y1 >>> 10) : a;
            a1 = dc_block_i ? a : 0;
            y1 = dc_block_i ? hist[0] : 0;
        end
        acc = 0;
        for (int k = 0; k < 12; k++) acc += H[4*k+ph] * hist[k];
        s = acc >>> 13;
        if (4 * (s < 0 ? -s : s) > peak) peak = 4 * (s < 0 ? -s : s);
        else peak -= peak >>> 12;
        check(out_o.sample, 28'(s));
        check(out_o.peak, 28'(peak));
        ph = (ph + 1) % 4;
    end

    // Reset also wipes the reference, so stale history would show up
    task automatic do_reset;
        rst_n_i = 1'b0;
        repeat (16) @(negedge clk_i);
        check({out_valid_o, in_ready_o, out_o.sample}, 28'h4000000);
        check(out_o.peak, 28'h0);
        hist = '{default: 0};
        {peak, a1, y1, ph} = '0;
        takes.delete();
        rst_n_i = 1'b1;
    endtask : do_reset

    task automatic burst(input logic signed [23:0] x, input int n,
                         input int gap);
        repeat (n) i_src.push(x, gap);
    endtask : burst

    // Fixed wait covers the four output phases of the last sample
    task automatic drain(input string name);
        repeat (8) @(negedge clk_i);
        check(28'(takes.size() * 4 + ph), 28'h0);
        $display("test %s done", name);
    endtask : drain

    task automatic t_impulse;
        burst(24'sh7fffff, 1, 0);
        burst(24'sh0, 13, 2);
        burst(-24'sh800000, 1, 0);
        burst(24'sh0, 13, 0);
        drain("impulse and decay");
    endtask : t_impulse

    task automatic t_dc;
        burst(24'sh200000, 14, 0);
        drain("dc kept");
        check(out_o.sample, 28'd525120);
        dc_block_i = 1'b1;
        burst(24'sh200000, 14, 1);
        burst(-24'sh100000, 4, 0);
        drain("dc blocked");
        dc_block_i = 1'b0;
    endtask : t_dc

    // Reset lands mid-burst; the next impulse must see empty history
    task automatic t_reset_mid;
        burst(24'sh3fffff, 3, 0);
        do_reset();
        burst(-24'sh400000, 1, 0);
        burst(24'sh0, 12, 0);
        drain("reset mid-run");
    endtask : t_reset_mid

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Watchdog sized well above the 76 samples sent
    initial begin
        #(20 * 20000);
        n_mismatch++;
        conclude();
    end

    initial begin
        do_reset();
        t_impulse();
        t_dc();
        t_reset_mid();
        conclude();
    end
endmodule : tb
